/* bench/sensor_model.sv */
// behavioural switched sensor and converter answering triggers
module sensor_model (
    input  wire logic        mclk_in,    // system clock
    input  wire logic        trigger_in, // start one conversion
    input  wire logic [3:0]  delay_in,   // conversion latency
    output logic             done_out,   // end of conversion pulse
    output logic [15:0]      result_out  // converted value
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0]  left;
    logic        busy;
    logic [15:0] code;

    initial begin
        left = 4'h0;
        busy = 1'b0;
        code = 16'h0a50;
        done_out = 1'b0;
        result_out = 16'h5aa5;
    end

    // ------------------------------------------------------------
    // conversion engine
    // ------------------------------------------------------------
    // one result per trigger, held until the next one
    always @(posedge mclk_in) begin
        done_out <= 1'b0;
        if (trigger_in && !busy) begin
            busy <= 1'b1;
            left <= delay_in;
        end else if (busy && left != 4'h0) begin
            left <= left - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            done_out <= 1'b1;
            result_out <= code;
            code <= code + 16'h0111; // new value each time
        end
    end
endmodule

/* bench/sensor_power_sample_sequencer_tb.sv */
// self-checking bench of the sensor power sample sequencer
module sensor_power_sample_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sensor_seq_pkg::*;

    localparam int P = 200; // short period count
    localparam int S = 20;  // short settling count
    localparam int C = 50;  // short conversion count

    logic        mclk, rst_n, rearm, xdone, ram_rdy, pdone, done;
    logic        pin, snz, irq, trig, halt, ramv;
    logic [3:0]  dly;
    logic [7:0]  latch, mode;
    logic [15:0] res, raddr, rdata;
    logic [15:0] got_res [4];
    int          error_cnt, check_count, n;
    time         last_irq, t_on;

    assign done = pdone | xdone; // bench may add a stray end

    sensor_power_sample_sequencer #(.PERIOD_CYC(P), .SETTLE_CYC(S),
        .CONV_CYC(C)) sensor_power_sample_sequencer_i (
        .mclk_in(mclk), .reset_n_in(rst_n),
        .power_on_val_in(8'h01), .power_off_val_in(8'h00),
        .snooze_val_in(8'h04), .rearm_in(rearm),
        .conv_done_in(done), .conv_result_in(res),
        .ram_ready_in(ram_rdy),
        .sensor_power_enable_pin_out(pin),
        .sensor_port_latch_out(latch),
        .converter_mode_control_out(mode),
        .converter_snooze_wake_bit_out(snz),
        .interval_tick_irq_out(irq), .conv_trigger_out(trig),
        .chain_halted_out(halt), .ram_valid_out(ramv),
        .ram_addr_out(raddr), .ram_data_out(rdata));

    sensor_model sensor_model_i (.mclk_in(mclk), .trigger_in(trig),
        .delay_in(dly), .done_out(pdone), .result_out(res));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always #5 mclk = ~mclk;

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1; // drive and sample just after the edge
    endtask

    task automatic chk_val(input logic [15:0] got, exp, input string s);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s %h not %h", $time, s, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, lo, hi, input string s);
        check_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("wrong value at %0t: %s %0d", $time, s, got);
        end
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return pin;
            1: return irq;
            2: return done;
            default: return ramv;
        endcase
    endfunction

    // bounded wait, so a stuck design cannot hang the run
    task automatic wait_sig(input int w, output int k);
        k = 0;
        do begin
            step(1);
            k++;
        end while (sig(w) !== 1'b1 && k < 1000);
        if (k >= 1000) begin
            error_cnt++;
            $display("wrong value at %0t: wait %0d timed out", $time, w);
        end
    endtask

    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk_val(16'(pin), 16'h0, "pin in reset");
        chk_val(16'(latch), 16'h0, "latch in reset");
        chk_val(16'(ramv), 16'h0, "ram valid in reset");
    endtask

    task automatic t_power_on;
        rst_n = 1'b1;
        wait_sig(0, n);
        t_on = $time;
        // fire, then on-transfer, then pin: two edges past the underflow
        chk_cnt(n, P + 2, P + 2, "power on delay");
        chk_val(16'(latch), 16'h01, "latch on");
    endtask

    task automatic t_settle;
        wait_sig(1, n);
        last_irq = $time;
        chk_cnt(n, S, S + 2, "settle span");
        chk_val(16'(trig), 16'h0, "settle trigger");
        chk_val(16'(mode), 16'h04, "settle mode");
        chk_val(16'(halt), 16'h0, "settle halt");
    endtask

    // the ram side stalls through all four so the fifo fills
    task automatic t_conv(input int k);
        dly = k[0] ? 4'hc : 4'h3; // prompt and slow sensor
        wait_sig(1, n);
        chk_cnt(int'(($time - last_irq) / 10), C, C, "tick span");
        last_irq = $time;
        chk_val(16'(trig), 16'h1, "trigger on tick");
        wait_sig(2, n);
        got_res[k] = res;
        step(3);
        chk_val(16'(pin), 16'h0, "pin off");
        chk_val(16'(latch), 16'h00, "latch off");
        step(1);
        chk_val(16'(snz), 16'h0, "snooze cleared");
        step(1);
        chk_val(16'(mode), 16'h04, "snooze set");
        step(1);
        chk_val(16'(halt), 16'(k == 3), "halt after four");
    endtask

    task automatic t_refuse;
        xdone = 1'b1;
        step(1);
        xdone = 1'b0;
        step(6);
        chk_val(16'(latch), 16'h00, "ignored end latch");
        chk_val(16'(mode), 16'h04, "ignored end mode");
        chk_val(16'(halt), 16'h1, "still halted");
        chk_val(16'(ramv), 16'h0, "ignored end store");
    endtask

    task automatic t_drain;
        ram_rdy = 1'b1;
        for (int k = 0; k < 4; k++) begin
            chk_val(16'(ramv), 16'h1, "word held");
            chk_val(raddr, RESULT_BASE + 16'(2 * k), "ram addr");
            chk_val(rdata, got_res[k], "ram data");
            step(1);
        end
        ram_rdy = 1'b0;
        chk_val(16'(ramv), 16'h0, "fifo empty");
    endtask

    task automatic t_rearm;
        logic [15:0] r;
        rearm = 1'b1;
        step(1);
        rearm = 1'b0;
        chk_val(16'(halt), 16'h0, "rearm clears halt");
        ram_rdy = 1'b1;
        wait_sig(2, n);
        r = res;
        wait_sig(3, n);
        chk_val(raddr, RESULT_BASE, "wrapped addr");
        chk_val(rdata, r, "wrapped data");
        step(2);
        ram_rdy = 1'b0;
        wait_sig(0, n);
        chk_cnt(int'(($time - t_on) / 10) % P, 0, 0, "repeat on");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        rearm = 1'b0;
        xdone = 1'b0;
        ram_rdy = 1'b0;
        dly = 4'h3;
        error_cnt = 0;
        check_count = 0;
        step(8);
        t_reset();
        t_power_on();
        t_settle();
        for (int k = 0; k < 4; k++)
            t_conv(k);
        t_drain();
        t_refuse(); // fifo now empty, so a taken end would show
        t_rearm();
        test_done();
    end

    // whole run needs about six hundred cycles
    initial begin
        #100000;
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        test_done();
    end
endmodule

/* rtl/sensor_power_sample_sequencer.sv */
// sensor power switching and sampling sequencer with result fifo
// What this block does
// R1: period timer fires every 100 ms, activating transfers
// R2: period fire drives sensor power pin high
// R3: first power-on waits 10 ms before conversions
// R4: then interval ticks every 100 ms start conversions
// R5: four conversions per power-on, then cycle repeats
// R6: each end of conversion stores result to RAM
// R7: end of conversion: power low, snooze clear, set
// R8: power pin starts as output driven low
// R9: pin high means power on, low off
// R10: converter hardware-triggered by interval tick, one channel
// R11: converter one-shot, one result per trigger
// R12: period timer plain mode, 100 ms value
// R13: channel 0 writes on-value to latch each fire
// R14: result channel repeats over four words from ea00
// R15: power-off channel chains, normal mode, count four
// R16: channels 3 and 4 clear then set snooze
// R17: counts exhausted halt; software rearms with four
// R18: software picks settle and conversion compare values; here the SETTLE_CYC and CONV_CYC parameters fix them

// ------------------------------------------------------------
// result fifo
// ------------------------------------------------------------
module result_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk_in,      // system clock
    input  wire logic             reset_n_in,   // sync reset, low
    input  wire logic             in_valid_in,  // push request
    output logic                  in_ready_out, // room for a word
    input  wire logic [WIDTH-1:0] in_data_in,   // pushed word
    output logic                  out_valid_out,// word available
    input  wire logic             out_ready_in, // sink takes word
    output logic [WIDTH-1:0]      out_data_out  // head word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      fill;
    logic             push;
    logic             pop;

    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_data_out  = mem[rd_ptr];

    // storage has no reset, only pointers, fill and flags do
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // fill level drives honest full and empty flags
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            fill          <= '0;
            in_ready_out  <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            if (push && !pop) begin
                fill          <= fill + 1'b1;
                in_ready_out  <= (fill != (AW+1)'(DEPTH - 1));
                out_valid_out <= 1'b1;
            end else if (pop && !push) begin
                fill          <= fill - 1'b1;
                in_ready_out  <= 1'b1;
                out_valid_out <= (fill != (AW+1)'(1));
            end
        end
    end
endmodule

// ------------------------------------------------------------
// sequencer top
// ------------------------------------------------------------
module sensor_power_sample_sequencer
    import sensor_seq_pkg::*;
#(
    parameter int PERIOD_CYC = PERIOD_CYCLES, // power-on period
    parameter int SETTLE_CYC = SETTLE_CYCLES, // settling wait
    parameter int CONV_CYC   = CONV_CYCLES    // conversion period
) (
    input  wire logic        mclk_in,         // 100 MHz clock
    input  wire logic        reset_n_in,      // sync reset, low
    input  wire logic [7:0]  power_on_val_in, // on byte for latch
    input  wire logic [7:0]  power_off_val_in,// off / snooze clr byte
    input  wire logic [7:0]  snooze_val_in,   // snooze set byte
    input  wire logic        rearm_in,        // reload counts, enable
    input  wire logic        conv_done_in,    // end of conversion
    input  wire logic [15:0] conv_result_in,  // conversion result
    input  wire logic        ram_ready_in,    // ram takes a word
    output logic             sensor_power_enable_pin_out, // power
    output logic [7:0]       sensor_port_latch_out,       // port
    output logic [7:0]       converter_mode_control_out,  // mode
    output logic             converter_snooze_wake_bit_out, // snooze
    output logic             interval_tick_irq_out, // tick pulse
    output logic             conv_trigger_out,  // start conversion
    output logic             chain_halted_out,  // counts exhausted
    output logic             ram_valid_out,     // ram write valid
    output logic [15:0]      ram_addr_out,      // ram write address
    output logic [15:0]      ram_data_out       // ram write data
);
    logic [31:0]  period_cnt;
    logic         period_fire;
    logic         on_pending;
    logic [31:0]  it_cnt;
    logic         it_run;
    logic         settled;
    logic         tick;
    chain_state_e state;
    logic [2:0]   chain_left;
    logic [1:0]   slot;
    logic         fifo_ready;
    logic         fifo_valid;
    ram_word_s    push_word;
    ram_word_s    head_word;
    logic         push;

    // ------------------------------------------------------------
    // period timer: down counter, underflow every period
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            period_cnt  <= 32'(PERIOD_CYC - 1);
            period_fire <= 1'b0;
        end else begin
            period_fire <= (period_cnt == 32'h0);              // [R1] [R12]
            period_cnt  <= (period_cnt == 32'h0) ?
                           32'(PERIOD_CYC - 1) : period_cnt - 1'b1;
        end
    end

    // on-transfer waits if the off-transfer owns the latch this cycle
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            on_pending <= 1'b0;
        end else if (period_fire) begin
            on_pending <= 1'b1;                                // [R13]
        end else if (state != CH_PWR_OFF) begin
            on_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // port latch and power pin
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            sensor_port_latch_out <= LATCH_RESET;              // [R8]
        end else if (state == CH_PWR_OFF) begin
            sensor_port_latch_out <= power_off_val_in;         // [R7] [R15]
        end else if (on_pending) begin
            sensor_port_latch_out <= power_on_val_in;          // [R2] [R13]
        end
    end

    // pin mirrors latch bit: high powers the sensor
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            sensor_power_enable_pin_out <= 1'b0;               // [R8]
        end else if (state == CH_PWR_OFF) begin
            sensor_power_enable_pin_out <= power_off_val_in[POWER_BIT]; // [R9]
        end else if (on_pending) begin
            sensor_power_enable_pin_out <= power_on_val_in[POWER_BIT]; // [R9]
        end
    end

    // ------------------------------------------------------------
    // interval timer: settle once, then conversion period
    // ------------------------------------------------------------
    assign tick = it_run && (it_cnt == 32'h0);

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            it_run  <= 1'b0;
            settled <= 1'b0;
            it_cnt  <= 32'h0;
        end else if (!it_run && !settled &&
                     sensor_power_enable_pin_out) begin
            it_run <= 1'b1;                                    // [R3]
            it_cnt <= 32'(SETTLE_CYC - 1);
        end else if (tick) begin
            settled <= 1'b1;
            it_cnt  <= 32'(CONV_CYC - 1);                      // [R4]
        end else if (it_run) begin
            it_cnt <= it_cnt - 1'b1;
        end
    end

    // the settle expiry arms snooze and clears the halt; it starts no conversion
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            interval_tick_irq_out <= 1'b0;
            conv_trigger_out      <= 1'b0;
        end else begin
            interval_tick_irq_out <= tick;
            conv_trigger_out      <= tick && settled &&
                converter_mode_control_out[SNOOZE_BIT];        // [R10] [R11]
        end
    end

    // ------------------------------------------------------------
    // converter mode register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            converter_mode_control_out <= MODE_RESET;
        end else if (tick && !settled) begin
            converter_mode_control_out <= SNOOZE_ON;
        end else if (state == CH_SNZ_CLR) begin
            converter_mode_control_out <= power_off_val_in;    // [R7] [R16]
        end else if (state == CH_SNZ_SET) begin
            converter_mode_control_out <= snooze_val_in;       // [R7] [R16]
        end
    end

    assign converter_snooze_wake_bit_out =
        converter_mode_control_out[SNOOZE_BIT];

    // ------------------------------------------------------------
    // chained transfers on end of conversion
    // ------------------------------------------------------------
    // conversions arrive a period apart, so a busy chain drops none unless it stalls in CH_STORE on a full fifo
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            state <= CH_IDLE;
        end else begin
            case (state)
                CH_IDLE: begin
                    if (conv_done_in && !chain_halted_out) begin
                        state <= CH_STORE;                     // [R6]
                    end
                end
                CH_STORE: begin
                    if (fifo_ready) begin
                        state <= CH_PWR_OFF;                   // [R15]
                    end
                end
                CH_PWR_OFF: state <= CH_SNZ_CLR;               // [R16]
                CH_SNZ_CLR: state <= CH_SNZ_SET;               // [R16]
                CH_SNZ_SET: state <= CH_IDLE;
                default:    state <= CH_IDLE;
            endcase
        end
    end

    // activation halts once the chain counts run out; a halt landing
    // with a rearm wins, so a finished chain is never lost
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            chain_left       <= CHAIN_COUNT;
            chain_halted_out <= 1'b1;
        end else begin
            if (rearm_in) begin
                chain_left <= CHAIN_COUNT;                     // [R17]
            end else if (state == CH_SNZ_SET) begin
                chain_left <= chain_left - 1'b1;
            end
            if (state == CH_SNZ_SET && chain_left == 3'h1) begin
                chain_halted_out <= 1'b1;                      // [R5] [R17]
            end else if (rearm_in || (tick && !settled)) begin
                chain_halted_out <= 1'b0;
            end
        end
    end

    // result slot wraps after four words
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            slot <= 2'h0;
        end else if (push) begin
            slot <= (slot == LAST_SLOT) ? 2'h0 : slot + 1'b1;  // [R14]
        end
    end

    assign push           = (state == CH_STORE) && fifo_ready;
    assign push_word.addr = RESULT_BASE + 16'(RESULT_STEP * slot); // [R14]
    assign push_word.data = conv_result_in;                    // [R6]

    // ------------------------------------------------------------
    // result buffer toward ram
    // ------------------------------------------------------------
    result_fifo #(
        .WIDTH ($bits(ram_word_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_in       (mclk_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (state == CH_STORE),
        .in_ready_out  (fifo_ready),
        .in_data_in    (push_word),
        .out_valid_out (fifo_valid),
        .out_ready_in  (ram_ready_in),
        .out_data_out  (head_word)
    );

    assign ram_valid_out = fifo_valid;
    assign ram_addr_out  = head_word.addr;
    assign ram_data_out  = head_word.data;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_period_reload: assert property ( // [R1] [R12]
        @(posedge mclk_in) disable iff (!reset_n_in)
        period_fire |-> period_cnt == 32'(PERIOD_CYC - 1))
        else $error("period timer did not reload");

    a_power_on: assert property ( // [R2] [R9]
        @(posedge mclk_in) disable iff (!reset_n_in)
        on_pending && state != CH_PWR_OFF |=>
        sensor_power_enable_pin_out == $past(power_on_val_in[POWER_BIT]))
        else $error("power pin not driven on");

    a_settle_first: assert property ( // [R3]
        @(posedge mclk_in) disable iff (!reset_n_in)
        conv_trigger_out |-> settled && $past(settled))
        else $error("conversion before settling");

    a_tick_trigger: assert property ( // [R4] [R10]
        @(posedge mclk_in) disable iff (!reset_n_in)
        tick && settled && converter_snooze_wake_bit_out
        |=> conv_trigger_out ##1 !conv_trigger_out)
        else $error("tick did not start one conversion");

    a_halt_after4: assert property ( // [R5] [R17]
        @(posedge mclk_in) disable iff (!reset_n_in)
        state == CH_SNZ_SET && chain_left == 3'h1 && !rearm_in
        |=> chain_halted_out && chain_left == 3'h0)
        else $error("chain not halted after fourth");

    a_store_addr: assert property ( // [R6] [R14]
        @(posedge mclk_in) disable iff (!reset_n_in)
        push |-> push_word.addr[15:3] == RESULT_BASE[15:3]
        && push_word.addr[2:0] == {slot, 1'b0})
        else $error("result stored at wrong address");

    a_chain_order: assert property ( // [R7] [R15] [R16]
        @(posedge mclk_in) disable iff (!reset_n_in)
        state == CH_PWR_OFF |=> state == CH_SNZ_CLR
        ##1 state == CH_SNZ_SET ##1 state == CH_IDLE)
        else $error("chain order broken");

    a_snooze_set: assert property ( // [R7] [R16]
        @(posedge mclk_in) disable iff (!reset_n_in)
        state == CH_SNZ_SET |=>
        converter_mode_control_out == $past(snooze_val_in))
        else $error("snooze not set again");

    a_pin_reset: assert property ( // [R8]
        @(posedge mclk_in)
        !reset_n_in |=> !sensor_power_enable_pin_out
        && sensor_port_latch_out == LATCH_RESET)
        else $error("power pin not low after reset");

    c_power_on: cover property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        $rose(sensor_power_enable_pin_out));
    c_store: cover property (
        @(posedge mclk_in) disable iff (!reset_n_in) push);
    c_halt: cover property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        $rose(chain_halted_out));
    c_fifo_full: cover property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        !fifo_ready && state == CH_STORE);
endmodule

/* rtl/sensor_seq_pkg.sv */
// constants, states and carriers of the sensor power sample sequencer
package sensor_seq_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;   // mclk_in rate
    localparam int CYC_PER_MS    = CLK_HZ / 1000;
    localparam int PERIOD_MS     = 100;           // power-on period
    localparam int SETTLE_MS     = 10;            // sensor settling
    localparam int CONV_MS       = 100;           // conversion period
    localparam int PERIOD_CYCLES = PERIOD_MS * CYC_PER_MS;
    localparam int SETTLE_CYCLES = SETTLE_MS * CYC_PER_MS;
    localparam int CONV_CYCLES   = CONV_MS * CYC_PER_MS;

    // ------------------------------------------------------------
    // transfer layout and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RESULT_BASE  = 16'hea00; // first result word
    localparam logic [15:0] RESULT_STEP  = 16'h0002; // 16-bit results
    localparam logic [1:0]  LAST_SLOT    = 2'h3;     // four result words
    localparam logic [2:0]  CHAIN_COUNT  = 3'h4;     // chained transfers
    localparam logic [7:0]  LATCH_RESET  = 8'h00;    // sensor unpowered
    localparam logic [7:0]  MODE_RESET   = 8'h00;    // snooze off
    localparam logic [7:0]  SNOOZE_ON    = 8'h04;    // snooze-wake bit set
    localparam int          POWER_BIT    = 0;        // latch bit of pin
    localparam int          SNOOZE_BIT   = 2;        // mode bit of snooze
    localparam int          FIFO_DEPTH   = 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CH_IDLE    = 3'b000,
        CH_STORE   = 3'b001,
        CH_PWR_OFF = 3'b011,
        CH_SNZ_CLR = 3'b010,
        CH_SNZ_SET = 3'b110
    } chain_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } ram_word_s;

endpackage
